// >>> dv/gpd_bus_model.sv
// Bus partner model: controller as source, second acceptor, listener to the talker
module gpd_bus_model
    import gpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] dio_n,
    input wire logic dav_n,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    input wire logic eoi_n,
    output logic [7:0] m_dio,
    output logic m_atn,
    output logic m_eoi,
    output logic m_dav,
    output logic m_nrfd,
    output logic m_ndac
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each output is a pull-down enable; a released line goes to its pull-up
    initial begin
        {m_dio, m_atn, m_eoi, m_dav, m_nrfd, m_ndac} = '0;
    end
    // Bounded wait, so a stuck handshake returns a failure instead of hanging
    task automatic wait_on(input int sel, output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(negedge clk_sys);
            case (sel)
                0: ok = (dav_n === 1'b0);
                1: ok = (nrfd_n === 1'b1) && (ndac_n === 1'b0);
                2: ok = (ndac_n === 1'b1);
                default: ok = (dav_n === 1'b1);
            endcase
        end
    endtask
    // One byte from the single active controller; hold keeps a second acceptor busy
    task automatic send_byte(input logic atn, input logic [7:0] d, input logic e,
        input int hold, output logic ok);
        logic k1;
        logic k2;
        @(negedge clk_sys);
        m_atn = atn;
        m_nrfd = 1'b0;
        m_ndac = (hold != 0);
        m_dio = d;
        m_eoi = e;
        wait_on(1, k1);
        m_dav = 1'b1;
        repeat (hold) @(negedge clk_sys);
        m_ndac = 1'b0;
        wait_on(2, k2);
        m_dav = 1'b0;
        m_eoi = 1'b0;
        @(negedge clk_sys);
        m_dio = '0;
        ok = k1 & k2;
    endtask
    // Listen to the device as talker; stall holds not-ready before the byte
    task automatic recv_byte(input int stall, output logic [8:0] b, output logic ok);
        logic k2;
        m_nrfd = 1'b1;
        m_ndac = 1'b1;
        repeat (stall + 1) @(negedge clk_sys);
        m_nrfd = 1'b0;
        wait_on(0, ok);
        b = {~eoi_n, ~dio_n};
        m_nrfd = 1'b1;
        m_ndac = 1'b0;
        wait_on(3, k2);
        m_ndac = 1'b1;
        ok = ok & k2;
    endtask
    // Attention change; when released, stand as a not-ready acceptor
    task automatic set_atn(input logic a);
        @(negedge clk_sys);
        m_atn = a;
        m_nrfd = !a;
        m_ndac = !a;
    endtask
endmodule // gpd_bus_model

// >>> dv/tb.sv
// Self-checking bench for the instrument bus port with a bus partner model
module tb
    import gpd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, nrst, tx_valid, rx_ready, srq_req, ifc_n, ren_n, ok;
    logic tx_ready, rx_valid, listen_active, talk_active, remote;
    logic [4:0] prim_addr;
    gpd_byte_type tx_byte, rx_byte, b;
    logic [7:0] d_dio, m_dio;
    logic d_eoi, d_srq, d_dav, d_nrfd, d_ndac, m_atn, m_eoi, m_dav, m_nrfd, m_ndac;
    logic [8:0] got;
    gpd_byte_type exp_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    // Wired open-drain lines: low while any party pulls
    wire [7:0] dio_n = ~(d_dio | m_dio);
    wire dav_n = ~(d_dav | m_dav);
    wire nrfd_n = ~(d_nrfd | m_nrfd);
    wire ndac_n = ~(d_ndac | m_ndac);
    wire eoi_n = ~(d_eoi | m_eoi);
    gpd_port DUT (.clk_sys(clk_sys), .nrst(nrst), .prim_addr(prim_addr),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
        .listen_active(listen_active), .talk_active(talk_active), .remote(remote),
        .srq_req(srq_req), .dio_n_in(dio_n), .dio_n_out(), .dio_n_oe(d_dio),
        .atn_n_in(~m_atn), .ifc_n_in(ifc_n), .ren_n_in(ren_n), .eoi_n_in(eoi_n),
        .eoi_n_out(), .eoi_n_oe(d_eoi), .srq_n_out(), .srq_n_oe(d_srq),
        .dav_n_in(dav_n), .dav_n_out(), .dav_n_oe(d_dav),
        .nrfd_n_in(nrfd_n), .nrfd_n_out(), .nrfd_n_oe(d_nrfd),
        .ndac_n_in(ndac_n), .ndac_n_out(), .ndac_n_oe(d_ndac));
    gpd_bus_model bus (.clk_sys(clk_sys), .dio_n(dio_n), .dav_n(dav_n), .nrfd_n(nrfd_n),
        .ndac_n(ndac_n), .eoi_n(eoi_n), .m_dio(m_dio), .m_atn(m_atn), .m_eoi(m_eoi),
        .m_dav(m_dav), .m_nrfd(m_nrfd), .m_ndac(m_ndac));
    // Free-running 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Listen or talk address built from the primary address
    function automatic logic [7:0] addr_of(input logic [4:0] pa, input logic talk);
        return {3'h0, pa} | (talk ? 8'h40 : 8'h20);
    endfunction
    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Command byte under attention, then let the address decode settle
    task automatic cmd(input logic [7:0] c);
        bus.send_byte(1'b1, c, 1'b0, 0, ok);
        check("cmd_handshake", 9'h1, {8'h0, ok});
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic push(input gpd_byte_type v);
        tx_byte = v;
        tx_valid = 1'b1;
        // Valid stays up so back-to-back calls stream; the caller lowers it
        @(negedge clk_sys);
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog sized well beyond both passes
    initial begin
        #(50 * 30000);
        n_mismatch++;
        finish_test();
    end
    // Main sequence: reset, then two passes with the low and a random address
    initial begin
        void'($urandom(11137));
        {nrst, tx_valid, rx_ready, srq_req, prim_addr, tx_byte} = '0;
        {ifc_n, ren_n} = 2'b11;
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("reset_out", 9'h10, {4'h0, tx_ready, rx_valid, listen_active, talk_active, d_dav});
        check("reset_oe", 9'h0, {d_dio, d_nrfd | d_ndac | d_eoi});
        srq_req = 1'b1;
        ren_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("srq_remote", 9'h3, {7'h0, d_srq, remote});
        srq_req = 1'b0;
        for (int pass = 0; pass < 2; pass++) begin
            prim_addr = (pass == 0) ? 5'h00 : 5'($urandom_range(30, 1));
            cmd(addr_of(prim_addr, 1'b0));
            check("listen", 9'h2, {7'h0, listen_active, talk_active});
            cmd(8'h60 | 8'($urandom_range(31, 0)));
            check("secondary", 9'h2, {7'h0, listen_active, talk_active});
            for (int k = 0; k < 6; k++) begin
                b = {k == 5, 8'($urandom)};
                bus.send_byte(1'b0, b.data, b.eoi, k % 3 * 4, ok);
                if (k == 2) begin
                    repeat (10) @(negedge clk_sys);
                    check("rx_hold_nrfd", 9'h1, {8'h0, d_nrfd});
                end
                check("rx_ok", 9'h1, {8'h0, ok & rx_valid});
                check("rx_byte", b, rx_byte);
                rx_ready = 1'b1;
                @(negedge clk_sys);
                rx_ready = 1'b0;
            end
            cmd(8'h3f);
            bus.set_atn(1'b0);
            repeat (6) @(negedge clk_sys);
            check("unlisten", 9'h0, {6'h0, listen_active, d_nrfd, d_ndac});
            cmd(addr_of(prim_addr, 1'b1));
            check("talk", 9'h1, {7'h0, listen_active, talk_active});
            while (tx_ready === 1'b1) begin
                b = {1'($urandom), 8'($urandom)};
                exp_q.push_back(b);
                push(b);
            end
            check("fifo_full", 9'(FIFO_DEPTH), 9'(exp_q.size()));
            tx_valid = 1'b1;
            repeat (3) @(negedge clk_sys);
            tx_valid = 1'b0;
            check("atn_no_source", 9'h0, {d_dio, d_dav});
            bus.set_atn(1'b0);
            while (exp_q.size() > 0) begin
                bus.recv_byte(exp_q.size() % 4 * 3, got, ok);
                check("tx_ok", 9'h1, {8'h0, ok});
                check("tx_byte", exp_q.pop_front(), got);
            end
            repeat (4) @(negedge clk_sys);
            check("fifo_empty", 9'h1, {8'h0, tx_ready});
            cmd(addr_of(prim_addr ^ 5'h01, 1'b1));
            bus.set_atn(1'b0);
            b = {1'b0, 8'($urandom)};
            exp_q.push_back(b);
            push(b);
            tx_valid = 1'b0;
            repeat (10) @(negedge clk_sys);
            check("untalk", 9'h0, {talk_active, d_dio});
            cmd(addr_of(prim_addr, 1'b0));
            ifc_n = 1'b0;
            repeat (4) @(negedge clk_sys);
            ifc_n = 1'b1;
            repeat (4) @(negedge clk_sys);
            check("ifc", 9'h0, {7'h0, listen_active, talk_active});
        end
        finish_test();
    end
endmodule // tb

// >>> verilog/gpd_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module gpd_fifo
    import gpd_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers carry one extra wrap bit so full and empty differ
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    // Full when pointers differ only in the wrap bit
    always_comb begin
        in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
        out_valid = (wr_reg != rd_reg);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        out_data = mem[rd_reg[AW-1:0]];
    end

    // Pointer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Memory write, no reset needed on storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule // gpd_fifo

// >>> verilog/gpd_pkg.sv
// Shared constants, bus codes and carrier types for the instrument bus port
package gpd_pkg;
    // Bus geometry
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    // Address groups, seven command bits, bit 8 of the byte ignored
    localparam logic [6:0] LISTEN_BASE = 7'h20;
    localparam logic [6:0] TALK_BASE = 7'h40;
    localparam logic [6:0] UNLISTEN_CODE = 7'h3f;
    localparam logic [1:0] TALK_GROUP = 2'h2;
    localparam logic [1:0] SECONDARY_GROUP = 2'h3;
    // Data settle time before the valid strobe
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_SETTLE_NS = 100;
    localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SETTLE_CNT = 2'(SETTLE_CYC);
    // One byte with its end marker
    typedef struct packed {
        logic eoi;
        logic [7:0] data;
    } gpd_byte_type;
    // Bus inputs in true-high form after inversion
    typedef struct packed {
        logic [7:0] dio;
        logic atn;
        logic ifc;
        logic ren;
        logic eoi;
        logic dav;
        logic nrfd;
        logic ndac;
    } gpd_pins_type;
    localparam gpd_pins_type PINS_RESET = '0;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;
    // Acceptor states
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_NOT_READY = 2'b01,
        ACC_READY = 2'b10,
        ACC_ACCEPT = 2'b11
    } gpd_acc_type;
    // Source states
    typedef enum logic [2:0] {
        SRC_IDLE = 3'b000,
        SRC_SETTLE = 3'b001,
        SRC_WAIT = 3'b010,
        SRC_VALID = 3'b011,
        SRC_RELEASE = 3'b100
    } gpd_src_type;
endpackage

// >>> verilog/gpd_port.sv
// Instrument bus port: addressing, acceptor and source handshakes
module gpd_port
    import gpd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [4:0] prim_addr,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire gpd_byte_type tx_byte,
    output logic rx_valid,
    input wire logic rx_ready,
    output gpd_byte_type rx_byte,
    output logic listen_active,
    output logic talk_active,
    output logic remote,
    input wire logic srq_req,
    input wire logic [7:0] dio_n_in,
    output logic [7:0] dio_n_out,
    output logic [7:0] dio_n_oe,
    input wire logic atn_n_in,
    input wire logic ifc_n_in,
    input wire logic ren_n_in,
    input wire logic eoi_n_in,
    output logic eoi_n_out,
    output logic eoi_n_oe,
    output logic srq_n_out,
    output logic srq_n_oe,
    input wire logic dav_n_in,
    output logic dav_n_out,
    output logic dav_n_oe,
    input wire logic nrfd_n_in,
    output logic nrfd_n_out,
    output logic nrfd_n_oe,
    input wire logic ndac_n_in,
    output logic ndac_n_out,
    output logic ndac_n_oe
);
    // Reset release synchroniser
    logic [1:0] rst_sync_reg;
    logic rst_n;
    // Pin synchroniser stages, true-high
    gpd_pins_type pin_meta_reg, sy;
    gpd_pins_type pin_raw;
    // Acceptor group
    gpd_acc_type acc_reg, acc_next;
    gpd_byte_type rx_reg, rx_next;
    logic rx_valid_reg, rx_valid_next;
    logic acc_en, capture, cap_cmd;
    logic [6:0] cmd;
    // Address group
    logic listen_reg, listen_next, talk_reg, talk_next;
    // Source group
    gpd_src_type src_reg, src_next;
    gpd_byte_type out_reg, out_next;
    logic [1:0] cnt_reg, cnt_next;
    logic [7:0] dio_oe_reg, dio_oe_next;
    logic src_en;
    // FIFO drain side
    logic fifo_valid, fifo_pop;
    gpd_byte_type fifo_byte;

    // Reset is asserted at once and released after two clean edges
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= RST_SYNC_RESET;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Low on the wire means true, so every input is inverted once here
    assign pin_raw = {~dio_n_in, ~atn_n_in, ~ifc_n_in, ~ren_n_in,
                      ~eoi_n_in, ~dav_n_in, ~nrfd_n_in, ~ndac_n_in};

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= PINS_RESET;
            sy <= PINS_RESET;
        end else begin
            pin_meta_reg <= pin_raw;
            sy <= pin_meta_reg;
        end
    end

    // Acceptor takes part during attention or while addressed to listen
    assign acc_en = sy.atn || listen_reg;
    assign capture = (acc_reg == ACC_READY) && sy.dav;
    assign cap_cmd = capture && sy.atn;
    assign cmd = sy.dio[6:0];

    // Acceptor next state and received byte
    always_comb begin
        acc_next = acc_reg;
        rx_next = rx_reg;
        rx_valid_next = rx_valid_reg && !rx_ready;
        case (acc_reg)
            ACC_IDLE: begin
                // Hold both lines as soon as we join in
                if (acc_en) begin
                    acc_next = ACC_NOT_READY;
                end
            end
            ACC_NOT_READY: begin
                // Ready once valid is gone and, outside attention, the last byte is handed on
                if (!acc_en) begin
                    acc_next = ACC_IDLE;
                end else if (!sy.dav && (sy.atn || !rx_valid_reg)) begin
                    acc_next = ACC_READY;
                end
            end
            ACC_READY: begin
                if (capture) begin
                    acc_next = ACC_ACCEPT;
                    if (!sy.atn && listen_reg) begin
                        // Data byte goes to the user side
                        rx_next = '{eoi: sy.eoi, data: sy.dio};
                        rx_valid_next = 1'b1;
                    end
                end else if (!acc_en) begin
                    acc_next = ACC_IDLE;
                end else if (!sy.atn && rx_valid_reg) begin
                    acc_next = ACC_NOT_READY;
                end
            end
            ACC_ACCEPT: begin
                // Stay accepted until the source drops valid
                if (!sy.dav) begin
                    acc_next = acc_en ? ACC_NOT_READY : ACC_IDLE;
                end
            end
            default: begin
                acc_next = ACC_IDLE;
            end
        endcase
    end

    // Acceptor registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= ACC_IDLE;
            rx_reg <= '0;
            rx_valid_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            rx_reg <= rx_next;
            rx_valid_reg <= rx_valid_next;
        end
    end

    // Address decode on command bytes; bit 8 of the byte is ignored
    always_comb begin
        listen_next = listen_reg;
        talk_next = talk_reg;
        if (sy.ifc) begin
            listen_next = 1'b0;
            talk_next = 1'b0;
        end else if (cap_cmd) begin
            if (cmd == (LISTEN_BASE | {2'h0, prim_addr})) begin
                listen_next = 1'b1;
            end else if (cmd == UNLISTEN_CODE) begin
                listen_next = 1'b0;
            end
            // Another talk address or untalk removes us, ours selects us
            if (cmd == (TALK_BASE | {2'h0, prim_addr})) begin
                talk_next = 1'b1;
            end else if (cmd[6:5] == TALK_GROUP) begin
                talk_next = 1'b0;
            end
            // Secondary group falls through with no effect
        end
    end

    // Address registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            listen_reg <= 1'b0;
            talk_reg <= 1'b0;
        end else begin
            listen_reg <= listen_next;
            talk_reg <= talk_next;
        end
    end

    // Talk only while addressed and the controller is not in attention
    assign src_en = talk_reg && !sy.atn && !sy.ifc;
    assign fifo_pop = (src_reg == SRC_IDLE) && src_en && fifo_valid;

    // Source next state
    always_comb begin
        src_next = src_reg;
        out_next = out_reg;
        cnt_next = cnt_reg;
        case (src_reg)
            SRC_IDLE: begin
                if (fifo_pop) begin
                    out_next = fifo_byte;
                    cnt_next = SETTLE_CNT;
                    src_next = SRC_SETTLE;
                end
            end
            SRC_SETTLE: begin
                // Data on the lines for the settle time before the strobe
                if (!src_en) begin
                    src_next = SRC_IDLE;
                end else if (cnt_reg <= 2'h1) begin
                    src_next = SRC_WAIT;
                end else begin
                    cnt_next = cnt_reg - 2'h1;
                end
            end
            SRC_WAIT: begin
                if (!src_en) begin
                    src_next = SRC_IDLE;
                end else if (!sy.nrfd && sy.ndac) begin
                    src_next = SRC_VALID;
                end
            end
            SRC_VALID: begin
                // Wired line rises only when every acceptor is done
                if (!src_en) begin
                    src_next = SRC_IDLE;
                end else if (!sy.ndac) begin
                    src_next = SRC_RELEASE;
                end
            end
            SRC_RELEASE: begin
                src_next = SRC_IDLE;
            end
            default: begin
                src_next = SRC_IDLE;
            end
        endcase
        // Data pulls low only for true bits; held one cycle past the strobe
        case (src_next)
            SRC_SETTLE, SRC_WAIT, SRC_VALID, SRC_RELEASE: dio_oe_next = out_next.data;
            default: dio_oe_next = 8'h00;
        endcase
    end

    // Source registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_reg <= SRC_IDLE;
            out_reg <= '0;
            cnt_reg <= 2'h0;
            dio_oe_reg <= 8'h00;
        end else begin
            src_reg <= src_next;
            out_reg <= out_next;
            cnt_reg <= cnt_next;
            dio_oe_reg <= dio_oe_next;
        end
    end

    // Transmit buffer; the user side stalls when it is full
    gpd_fifo #(
        .WIDTH($bits(gpd_byte_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_byte),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_byte)
    );

    // Open-drain pins: output level is always low, enables do the work
    assign dio_n_out = 8'h00;
    assign dio_n_oe = dio_oe_reg;
    assign dav_n_out = 1'b0;
    assign dav_n_oe = (src_reg == SRC_VALID);
    assign eoi_n_out = 1'b0;
    assign eoi_n_oe = (src_reg == SRC_VALID) && out_reg.eoi;
    // Not-ready held only in the not-ready and accept states
    assign nrfd_n_out = 1'b0;
    assign nrfd_n_oe = (acc_reg == ACC_NOT_READY) || (acc_reg == ACC_ACCEPT);
    // Not-accepted let go after capture and while idle; the wire ANDs all acceptors
    assign ndac_n_out = 1'b0;
    assign ndac_n_oe = (acc_reg == ACC_NOT_READY) || (acc_reg == ACC_READY);
    assign srq_n_out = 1'b0;
    assign srq_n_oe = srq_req;
    // User-side status
    assign rx_valid = rx_valid_reg;
    assign rx_byte = rx_reg;
    assign listen_active = listen_reg;
    assign talk_active = talk_reg;
    assign remote = sy.ren;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_READY_FIRST: assert property (
        capture |-> $past(!nrfd_n_oe)
    ) else $error("byte taken while not-ready was held");
    AST_CAPTURE_THEN_ACCEPT: assert property (
        (capture && !sy.atn && listen_reg) |=>
            (!ndac_n_oe && rx_valid && rx_byte.data == $past(sy.dio))
    ) else $error("accept shown without captured byte");
    AST_READY_AGAIN: assert property (
        (acc_reg == ACC_ACCEPT && !sy.dav && acc_en) |=>
            nrfd_n_oe ##1 ($past(rx_valid_reg) || !nrfd_n_oe)
    ) else $error("listener not ready again after valid removed");
    AST_DATA_BEFORE_VALID: assert property (
        $rose(dav_n_oe) |-> $stable(dio_n_oe) && $past(dio_n_oe, 2) == dio_n_oe
    ) else $error("data changed around valid strobe");
    AST_SOURCE_WAITS: assert property (
        $rose(dav_n_oe) |-> $past(!sy.nrfd && sy.ndac)
    ) else $error("valid asserted before acceptors were ready");
    AST_VALID_DROPS: assert property (
        (dav_n_oe && !sy.ndac && src_en) |=> !dav_n_oe
    ) else $error("valid held after acceptance");
    AST_TALK_ONLY: assert property (
        (dio_n_oe != 8'h00) |-> talk_reg
    ) else $error("data driven while not talker");
    AST_LISTEN_ADDR: assert property (
        (cap_cmd && !sy.ifc && cmd == {2'h1, prim_addr}) |=> listen_active
    ) else $error("own listen address not recognised");
    AST_TALK_ADDR: assert property (
        (cap_cmd && !sy.ifc && cmd == {2'h2, prim_addr}) |=> talk_active
    ) else $error("own talk address not recognised");
    AST_SECONDARY_IGNORED: assert property (
        (cap_cmd && !sy.ifc && cmd[6:5] == SECONDARY_GROUP) |=>
            $stable(listen_reg) && $stable(talk_reg)
    ) else $error("secondary address changed selection");
    AST_UNLISTEN: assert property (
        (cap_cmd && cmd == UNLISTEN_CODE && prim_addr != 5'h1f) |=> !listen_active
    ) else $error("unlisten ignored");
    AST_ACCEPT_ONLY_AFTER: assert property (
        (acc_reg != ACC_IDLE && !ndac_n_oe) |-> $past(capture) || $past(acc_reg == ACC_ACCEPT)
    ) else $error("not-accepted released without capture");
    AST_CMD_NOT_DATA: assert property (
        $rose(rx_valid) |-> $past(!sy.atn)
    ) else $error("command byte delivered as data");

    COV_LISTEN_BYTE: cover property (capture && !sy.atn && listen_reg);
    COV_TALK_BYTE: cover property (dav_n_oe ##[1:20] $fell(dav_n_oe));
    COV_UNLISTEN: cover property (listen_reg ##1 !listen_reg);
    COV_FIFO_FULL: cover property (!tx_ready);
endmodule // gpd_port
